// ### rtl/pdt_cfg.svh
// Constants of the programmable down timer: offsets, fields, reset values.
// Assumes a 4-bit register port with a 5-bit address and three selectable timer clock pins.
// Operation
// - Low nibble read latches upper count nibbles
// - In 16-bit mode low read freezes 12 bits
// - Run and stop act on input clock fall
// - Stop request gets one more decrement first
// - Run bit reads one until really halted
// - Event mode counts from first event clock
// - Decrement on fall, underflow flag same edge
// - Reload after underflow settles on next rise
// - Toggle outputs gated by enables, may glitch
// - Fast oscillator is off after reset
// - Separate underflow and compare match flags
`ifndef PDT_CFG_SVH
`define PDT_CFG_SVH
`define PDT_AW 5
`define PDT_DW 4
`define PDT_CW 16
`define PDT_NOUT 4
`define PDT_OFS_CTRL 5'h00
`define PDT_OFS_SRC 5'h01
`define PDT_OFS_OUTEN 5'h02
`define PDT_OFS_RELOAD 5'h04
`define PDT_OFS_COUNT 5'h08
`define PDT_OFS_CMP 5'h0c
`define PDT_OFS_STATUS 5'h10
`define PDT_OFS_MASK 5'h11
`define PDT_CTRL_RUN 0
`define PDT_CTRL_FOSC 1
`define PDT_CTRL_WIDE 2
`define PDT_CTRL_PRESET 3
`define PDT_SRC_SLOW 2'h0
`define PDT_SRC_FAST 2'h1
`define PDT_SRC_EVENT 2'h2
`define PDT_ST_UNF 0
`define PDT_ST_CMP 1
`define PDT_RST_RELOAD 16'h0000
`define PDT_RST_CMP 16'h0000
`endif

// ### rtl/pdt_pkg.sv
// Types shared by the programmable down timer files.
// Assumes pdt_cfg.svh is on the include path.
`include "pdt_cfg.svh"
package pdt_pkg;
    // One register access from the CPU side
    typedef struct packed {
        logic [`PDT_AW-1:0] addr;
        logic [`PDT_DW-1:0] wdata;
        logic wr;
        logic rd;
    } pdt_bus_t;

    // Counter run state
    typedef enum logic {
        PDT_STOP,
        PDT_RUN
    } pdt_state_t;
endpackage

// ### rtl/pdt_sync.sv
// Two-flop synchroniser for a vector of unrelated asynchronous levels.
// Assumes each bit is an independent level, not a multi-bit word.
`timescale 1ns/1ns
module pdt_sync #(
    parameter int W = 3
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    if (W < 1) begin : g_chk
        $error("pdt_sync: W must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            meta <= '0;
            q_out <= '0;
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule // pdt_sync

// ### rtl/pdt_timer.sv
// Single-channel programmable down timer with nibble register port.
// Assumes timer clock pins are asynchronous to clock_in and much slower.
`timescale 1ns/1ns
module pdt_timer import pdt_pkg::*; #(
    parameter int CNT_W = `PDT_CW
) (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire pdt_bus_t bus_in,
    output logic [`PDT_DW-1:0] rdata_out,
    input wire logic slow_oscillator_in,
    input wire logic fast_oscillator_in,
    input wire logic event_clk_in,
    output logic fast_oscillator_en_out,
    output logic [`PDT_NOUT-1:0] timer_toggle_outputs_out,
    output logic irq_out
);
    if (CNT_W != `PDT_CW) begin : g_chk
        $error("pdt_timer: CNT_W must be 16 to match the nibble map");
    end

    // Register group match on the upper address bits
    function automatic logic in_group(input logic [`PDT_AW-1:0] a,
                                      input logic [`PDT_AW-1:0] base);
        in_group = (a[`PDT_AW-1:2] == base[`PDT_AW-1:2]);
    endfunction

    // Bit offset of the addressed nibble within a 16-bit value
    function automatic logic [3:0] nib_pos(input logic [`PDT_AW-1:0] a);
        nib_pos = {a[1:0], 2'b00};
    endfunction

    // Software visible state
    logic timer_run_ctrl;
    logic wide16;
    logic [1:0] src;
    logic [`PDT_NOUT-1:0] toggle_output_enables;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] compare;
    logic [1:0] status;
    logic [1:0] mask;

    // Counter state
    pdt_state_t state;
    logic [CNT_W-1:0] count;
    logic [CNT_W-5:0] hold;
    logic load_pend;
    logic [1:0] toggles;

    // Timer clock recovery
    logic [2:0] clk_sync;
    logic sel_clk;
    logic clk_prev;
    logic fall;
    logic rise;

    // Decoded values
    logic zero;
    logic dec_now;
    logic unf_evt;
    logic cmp_evt;
    logic preset_wr;
    logic [CNT_W-1:0] next_count;
    logic [CNT_W-1:0] load_val;
    logic [CNT_W-1:0] cmp_val;
    logic [1:0] evt;
    logic [1:0] clr;
    logic rd_low;

    // Timer clock pins pass two flops before any logic
    pdt_sync #(.W(3)) u_sync (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .d_in({event_clk_in, fast_oscillator_in, slow_oscillator_in}),
        .q_out(clk_sync)
    );

    // Source select from synchronised levels only
    always_comb begin
        case (src)
            `PDT_SRC_SLOW: sel_clk = clk_sync[0];
            `PDT_SRC_FAST: sel_clk = clk_sync[1];
            `PDT_SRC_EVENT: sel_clk = clk_sync[2];
            default: sel_clk = 1'b0;
        endcase
    end

    // Delayed copy for edge detection
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= sel_clk;
        end
    end

    assign fall = clk_prev & ~sel_clk;
    assign rise = ~clk_prev & sel_clk;

    // Decrement, underflow and compare decisions
    always_comb begin
        zero = wide16 ? (count == 16'h0000) : (count[7:0] == 8'h00);
        load_val = wide16 ? reload : {8'h00, reload[7:0]};
        cmp_val = wide16 ? compare : {8'h00, compare[7:0]};
        next_count = count - 16'h0001;
        if (!wide16) begin
            next_count[15:8] = 8'h00;
        end
        // Event mode: the starting event is already counted
        dec_now = fall && !load_pend &&
                  ((state == PDT_RUN) ||
                   (timer_run_ctrl && (src == `PDT_SRC_EVENT)));
        unf_evt = dec_now && zero;
        cmp_evt = dec_now && !zero && (next_count == cmp_val);
        evt = 2'b00;
        evt[`PDT_ST_UNF] = unf_evt;
        evt[`PDT_ST_CMP] = cmp_evt;
    end

    // Bus side decode
    always_comb begin
        preset_wr = bus_in.wr && (bus_in.addr == `PDT_OFS_CTRL) &&
                    bus_in.wdata[`PDT_CTRL_PRESET];
        clr = 2'b00;
        if (bus_in.wr && (bus_in.addr == `PDT_OFS_STATUS)) begin
            clr = bus_in.wdata[1:0];
        end
        rd_low = bus_in.rd && (bus_in.addr == `PDT_OFS_COUNT);
    end

    // Run state moves only on a fall of the input clock
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            state <= PDT_STOP;
        end else if (fall && !load_pend) begin
            case (state)
                PDT_STOP: begin
                    if (timer_run_ctrl) begin
                        state <= PDT_RUN;
                    end
                end
                PDT_RUN: begin
                    // The last decrement happens on this same edge
                    if (!timer_run_ctrl) begin
                        state <= PDT_STOP;
                    end
                end
                default: state <= PDT_STOP;
            endcase
        end
    end

    // Counter: preset, reload on rise, decrement on fall
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            count <= '0;
        end else if (preset_wr && (state == PDT_STOP)) begin
            count <= load_val;
        end else if (rise && load_pend) begin
            count <= load_val;
        end else if (dec_now) begin
            count <= next_count;
        end
    end

    // Reload window from underflow to the next rise
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            load_pend <= 1'b0;
        end else if (unf_evt) begin
            load_pend <= 1'b1;
        end else if (rise) begin
            load_pend <= 1'b0;
        end
    end

    // Control registers written by software
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            timer_run_ctrl <= 1'b0;
            fast_oscillator_en_out <= 1'b0;
            wide16 <= 1'b0;
            src <= `PDT_SRC_SLOW;
            toggle_output_enables <= '0;
            mask <= 2'b00;
        end else if (bus_in.wr) begin
            if (bus_in.addr == `PDT_OFS_CTRL) begin
                timer_run_ctrl <= bus_in.wdata[`PDT_CTRL_RUN];
                fast_oscillator_en_out <= bus_in.wdata[`PDT_CTRL_FOSC];
                wide16 <= bus_in.wdata[`PDT_CTRL_WIDE];
            end else if (bus_in.addr == `PDT_OFS_SRC) begin
                src <= bus_in.wdata[1:0];
            end else if (bus_in.addr == `PDT_OFS_OUTEN) begin
                toggle_output_enables <= bus_in.wdata[`PDT_NOUT-1:0];
            end else if (bus_in.addr == `PDT_OFS_MASK) begin
                mask <= bus_in.wdata[1:0];
            end
        end
    end

    // Reload and compare nibbles
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            reload <= `PDT_RST_RELOAD;
            compare <= `PDT_RST_CMP;
        end else if (bus_in.wr) begin
            if (in_group(bus_in.addr, `PDT_OFS_RELOAD)) begin
                reload[nib_pos(bus_in.addr) +: 4] <= bus_in.wdata;
            end else if (in_group(bus_in.addr, `PDT_OFS_CMP)) begin
                compare[nib_pos(bus_in.addr) +: 4] <= bus_in.wdata;
            end
        end
    end

    // Sticky flags, a new event beats a clear
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            status <= 2'b00;
        end else begin
            status <= evt | (status & ~clr);
        end
    end

    // Level interrupt from unmasked flags
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status & mask);
        end
    end

    // Low nibble read freezes every upper nibble
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            hold <= '0;
        end else if (rd_low) begin
            hold <= count[CNT_W-1:4];
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            rdata_out <= '0;
        end else if (bus_in.rd) begin
            if (bus_in.addr == `PDT_OFS_CTRL) begin
                rdata_out <= {1'b0, wide16, fast_oscillator_en_out,
                              timer_run_ctrl | (state == PDT_RUN)};
            end else if (bus_in.addr == `PDT_OFS_SRC) begin
                rdata_out <= {2'b00, src};
            end else if (bus_in.addr == `PDT_OFS_OUTEN) begin
                rdata_out <= toggle_output_enables;
            end else if (rd_low) begin
                rdata_out <= count[3:0];
            end else if (in_group(bus_in.addr, `PDT_OFS_COUNT)) begin
                rdata_out <= hold[nib_pos(bus_in.addr) - 4'h4 +: 4];
            end else if (in_group(bus_in.addr, `PDT_OFS_RELOAD)) begin
                rdata_out <= reload[nib_pos(bus_in.addr) +: 4];
            end else if (in_group(bus_in.addr, `PDT_OFS_CMP)) begin
                rdata_out <= compare[nib_pos(bus_in.addr) +: 4];
            end else if (bus_in.addr == `PDT_OFS_STATUS) begin
                rdata_out <= {2'b00, status};
            end else if (bus_in.addr == `PDT_OFS_MASK) begin
                rdata_out <= {2'b00, mask};
            end else begin
                rdata_out <= '0;
            end
        end
    end

    // Toggle states: bit 0 on underflow, bit 1 on compare match
    always_ff @(posedge clock_in) begin
        if (!rstn_in) begin
            toggles <= 2'b00;
        end else begin
            toggles <= toggles ^ evt;
        end
    end

    // Gating ignores the toggle phase, so a short pulse may appear
    for (genvar g = 0; g < `PDT_NOUT; g++) begin : g_tout
        always_ff @(posedge clock_in) begin
            if (!rstn_in) begin
                timer_toggle_outputs_out[g] <= 1'b0;
            end else begin
                timer_toggle_outputs_out[g] <=
                    toggle_output_enables[g] & toggles[g % 2];
            end
        end
    end

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rstn_in);

    // Readback of run stays high while still running
    a_run_readback: assert property (
        bus_in.rd && (bus_in.addr == `PDT_OFS_CTRL) && (state == PDT_RUN)
        |=> rdata_out[`PDT_CTRL_RUN])
        else $error("run bit read low while counter runs");

    // Start only on a fall with run requested
    a_start_on_fall: assert property (
        $rose(state == PDT_RUN) |-> $past(fall) && $past(timer_run_ctrl))
        else $error("counter started away from a falling edge");

    // Stop request on a fall halts with one last decrement on that same edge
    a_stop_decrement: assert property (
        (state == PDT_RUN) && !timer_run_ctrl && fall && !load_pend && !zero
        |=> (state == PDT_STOP) && (count == $past(count) - 16'h0001))
        else $error("stop did not take one last decrement");

    // Event mode counts the very first event
    a_event_first: assert property (
        (state == PDT_STOP) && timer_run_ctrl && (src == `PDT_SRC_EVENT)
        && fall && !load_pend && !zero && !preset_wr
        |=> count == $past(count) - 16'h0001)
        else $error("first event clock was not counted");

    // Underflow raises its flag on the same edge
    a_underflow_flag: assert property (
        (state == PDT_RUN) && fall && !load_pend && zero
        |=> status[`PDT_ST_UNF] && load_pend)
        else $error("underflow flag not raised on underflow");

    // Reload lands on the next rise and counting resumes
    a_reload_rise: assert property (
        load_pend && rise && !preset_wr
        |=> !load_pend && (count == $past(load_val)))
        else $error("reload value not loaded on rising edge");

    // Low read copies the upper count at once
    a_hold_capture: assert property (
        rd_low |=> hold == $past(count[CNT_W-1:4]))
        else $error("upper count not captured on low read");

    // Upper nibbles frozen until the next low read
    a_hold_frozen: assert property (
        !rd_low |=> $stable(hold))
        else $error("held upper count changed without low read");

    // Disabled toggle output 0 stays low
    a_toggle_gate: assert property (
        !toggle_output_enables[0] |=> !timer_toggle_outputs_out[0])
        else $error("toggle output high while disabled");

    // Fast oscillator off straight out of reset
    a_fast_off: assert property (
        $rose(rstn_in) |-> !fast_oscillator_en_out)
        else $error("fast oscillator enabled after reset");

    // Compare match raises its own flag
    a_cmp_flag: assert property (
        cmp_evt && !unf_evt |=> status[`PDT_ST_CMP])
        else $error("compare match flag not raised");
endmodule // pdt_timer

// ### verif/programmable_down_timer_tb_top.sv
// Self-checking bench for the programmable down timer through its nibble register port.
// Assumes pdt_pkg and pdt_timer are compiled first; the bench drives the timer clocks itself.
`timescale 1ns/1ns
`include "pdt_cfg.svh"
module programmable_down_timer_tb_top import pdt_pkg::*; ;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    pdt_bus_t bus = '0;
    logic [3:0] rdata;
    logic [2:0] tclk = 3'b111;
    logic fosc_en;
    logic [3:0] tog;
    logic irq;
    int miscompares = 0;
    int num_checks = 0;
    int sel = 0;

    // System clock, 100 MHz
    always #5 clock_in = ~clock_in;

    pdt_timer dut (
        .clock_in(clock_in),
        .rstn_in(rstn_in),
        .bus_in(bus),
        .rdata_out(rdata),
        .slow_oscillator_in(tclk[0]),
        .fast_oscillator_in(tclk[1]),
        .event_clk_in(tclk[2]),
        .fast_oscillator_en_out(fosc_en),
        .timer_toggle_outputs_out(tog),
        .irq_out(irq)
    );

    // One compare for every nibble-wide result
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe, released on the next edge; outputs settle 1 ns later
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        @(posedge clock_in);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clock_in);
        bus <= '0;
        #1;
    endtask

    // One-cycle read strobe; data stands from the following cycle until the next read
    task automatic rd(input logic [4:0] a, input logic [3:0] exp);
        @(posedge clock_in);
        bus <= '{a, 4'h0, 1'b0, 1'b1};
        @(posedge clock_in);
        bus <= '0;
        #1;
        chk(rdata, exp);
    endtask

    // Level change on the selected timer clock, long enough to pass the synchroniser
    task automatic tick(input logic lvl);
        @(posedge clock_in);
        tclk[sel] <= lvl;
        repeat (10) @(posedge clock_in);
    endtask

    // Full timer clock period: fall then rise
    task automatic pulse();
        tick(1'b0);
        tick(1'b1);
    endtask

    // Interrupt line as a nibble, two cycles after a register write
    task automatic chk_irq(input logic [3:0] exp);
        repeat (2) @(posedge clock_in);
        #1;
        chk({3'h0, irq}, exp);
    endtask

    // Summary line, verdict and end of run
    task automatic give_verdict();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        #200000;
        miscompares++;
        give_verdict();
    end

    // Main sequence
    initial begin
        repeat (2) @(posedge clock_in);
        rstn_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        // Reset values, unmapped address
        rd(`PDT_OFS_CTRL, 4'h0);
        rd(`PDT_OFS_SRC, 4'h0);
        rd(`PDT_OFS_OUTEN, 4'h0);
        rd(`PDT_OFS_STATUS, 4'h0);
        rd(`PDT_OFS_MASK, 4'h0);
        rd(`PDT_OFS_COUNT, 4'h0);
        rd(5'h1f, 4'h0);
        chk({3'h0, fosc_en}, 4'h0);
        chk(tog, 4'h0);
        chk({3'h0, irq}, 4'h0);
        wr(`PDT_OFS_CTRL, 4'h2);
        chk({3'h0, fosc_en}, 4'h1);
        // Start, decrement and stop for every clock source
        wr(`PDT_OFS_RELOAD, 4'h5);
        for (int s = 0; s < 3; s++) begin
            sel = s;
            wr(`PDT_OFS_SRC, s[3:0]);
            wr(`PDT_OFS_CTRL, 4'ha);
            rd(`PDT_OFS_COUNT, 4'h5);
            wr(`PDT_OFS_CTRL, 4'h3);
            pulse();
            rd(`PDT_OFS_COUNT, (s == 2) ? 4'h4 : 4'h5);
            pulse();
            rd(`PDT_OFS_COUNT, (s == 2) ? 4'h3 : 4'h4);
            wr(`PDT_OFS_CTRL, 4'h2);
            rd(`PDT_OFS_CTRL, 4'h3);
            pulse();
            rd(`PDT_OFS_COUNT, (s == 2) ? 4'h2 : 4'h3);
            rd(`PDT_OFS_CTRL, 4'h2);
            pulse();
            rd(`PDT_OFS_COUNT, (s == 2) ? 4'h2 : 4'h3);
        end
        // Compare match, underflow, reload, mask and flag clearing
        sel = 0;
        wr(`PDT_OFS_SRC, 4'h0);
        wr(`PDT_OFS_RELOAD, 4'h2);
        wr(`PDT_OFS_CMP, 4'h1);
        wr(`PDT_OFS_OUTEN, 4'h3);
        wr(`PDT_OFS_MASK, 4'h1);
        wr(`PDT_OFS_CTRL, 4'ha);
        wr(`PDT_OFS_CTRL, 4'h3);
        pulse();
        pulse();
        rd(`PDT_OFS_STATUS, 4'h2);
        chk(tog, 4'h2);
        chk({3'h0, irq}, 4'h0);
        wr(`PDT_OFS_STATUS, 4'h2);
        rd(`PDT_OFS_STATUS, 4'h0);
        pulse();
        tick(1'b0);
        rd(`PDT_OFS_STATUS, 4'h1);
        chk(tog, 4'h3);
        chk({3'h0, irq}, 4'h1);
        tick(1'b1);
        rd(`PDT_OFS_COUNT, 4'h2);
        pulse();
        rd(`PDT_OFS_COUNT, 4'h1);
        rd(`PDT_OFS_STATUS, 4'h3);
        chk(tog, 4'h1);
        wr(`PDT_OFS_MASK, 4'h0);
        chk_irq(4'h0);
        wr(`PDT_OFS_MASK, 4'h2);
        chk_irq(4'h1);
        wr(`PDT_OFS_STATUS, 4'h3);
        chk_irq(4'h0);
        wr(`PDT_OFS_OUTEN, 4'h0);
        repeat (2) @(posedge clock_in);
        chk(tog, 4'h0);
        wr(`PDT_OFS_CTRL, 4'h2);
        pulse();
        // 16-bit mode: low nibble read freezes the upper twelve bits
        wr(`PDT_OFS_CTRL, 4'h6);
        wr(`PDT_OFS_RELOAD, 4'h0);
        wr(`PDT_OFS_RELOAD + 5'h1, 4'h0);
        wr(`PDT_OFS_RELOAD + 5'h2, 4'h2);
        wr(`PDT_OFS_RELOAD + 5'h3, 4'h1);
        wr(`PDT_OFS_CTRL, 4'he);
        rd(`PDT_OFS_COUNT, 4'h0);
        wr(`PDT_OFS_CTRL, 4'h7);
        pulse();
        pulse();
        rd(`PDT_OFS_COUNT + 5'h1, 4'h0);
        rd(`PDT_OFS_COUNT + 5'h2, 4'h2);
        rd(`PDT_OFS_COUNT + 5'h3, 4'h1);
        rd(`PDT_OFS_COUNT, 4'hf);
        rd(`PDT_OFS_COUNT + 5'h1, 4'hf);
        rd(`PDT_OFS_COUNT + 5'h2, 4'h1);
        rd(`PDT_OFS_COUNT + 5'h3, 4'h1);
        wr(`PDT_OFS_CTRL, 4'h6);
        pulse();
        // No clock selected: a run request alone never moves the count
        wr(`PDT_OFS_SRC, 4'h3);
        rd(`PDT_OFS_SRC, 4'h3);
        wr(`PDT_OFS_CTRL, 4'h7);
        pulse();
        rd(`PDT_OFS_COUNT, 4'he);
        rd(`PDT_OFS_CTRL, 4'h7);
        wr(`PDT_OFS_CTRL, 4'h6);
        give_verdict();
    end
endmodule // programmable_down_timer_tb_top
